/* flash_cmd_map.svh */
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

`define OP_READ_FAST 8'h0B
`define OP_READ_SLOW 8'h03
`define OP_READ_DUAL 8'h3B
`define OP_PAGE_ERASE 8'h81
`define OP_BLK4_ERASE 8'h20
`define OP_BLK32_ERASE_A 8'h52
`define OP_BLK32_ERASE_B 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_CHIP_ERASE_C 8'h62
`define OP_PROGRAM 8'h02
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_OTP_PROGRAM 8'h9B
`define OP_OTP_READ 8'h77
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WR1 8'h01
`define OP_STATUS_WR2 8'h31
`define OP_SOFT_RESET 8'hF0
`define OP_ID_READ 8'h9F
`define OP_ID_LEGACY 8'h15
`define OP_POWER_DOWN 8'hB9
`define OP_POWER_RESUME 8'hAB
`define OP_ULTRA_DOWN 8'h79

`define ADDR_TOP 17'h1FFFF
`define ADDR_KEEP_BITS 17
`define ADDR_BYTES 3
`define OTP_DUMMY_BYTES 2

`endif

/* flash_cmd_pkg.sv */
package flash_cmd_pkg;

    typedef enum logic [1:0] {
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA
    } phase_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_IGNORE
    } ctrl_state_t;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_READ_SINGLE,
        CMD_READ_DUAL,
        CMD_ADDR_ONLY,
        CMD_BARE,
        CMD_ADDR_DATA,
        CMD_OTP_READ,
        CMD_DATA_IN,
        CMD_DATA_OUT,
        CMD_ONE_DATA
    } cmd_class_t;

endpackage

/* spi_pin_sync.sv */
`timescale 1ns/100ps
module spi_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync,
    output logic [WIDTH-1:0] pin_prev
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = pin_in;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2;
    end

    // chip select idles high, clock idles low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= '{stage1: WIDTH'(1), stage2: WIDTH'(1), stage3: WIDTH'(1)};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_sync = state_reg.stage2;
    assign pin_prev = state_reg.stage3;
endmodule

/* serial_flash_command_read.sv */
`timescale 1ns/100ps
`include "flash_cmd_map.svh"

// How it works
// - chip select low starts; first byte opcode
// - every byte shifts most significant bit first
// - chip select high ends the command
// - unknown opcode starts no operation
// - unknown opcode ignores input until reselect
// - early deselect performs nothing, back idle
// - address bits 23 to 17 ignored
// - 0Bh read: three address, one dummy
// - 03h read: three address, no dummy
// - read address counter auto increments, streams
// - single read shifts one bit per clock
// - counter wraps 1FFFFh to zero seamlessly
// - deselect stops single read, output released
// - 3Bh dual read: address then dummy
// - dual read: two bits per clock
// - deselect releases both dual read pins
// - chip erase opcodes are bare opcodes
// - program 02h: address then data bytes
// - OTP program 9Bh, read 77h two dummies
// - status read 05h; writes one byte
// - id reads 9Fh and 15h, no address
// - power commands are bare opcodes
// - sample rising edges, drive falling edges
module serial_flash_command_read #(
    parameter int ADDR_W = `ADDR_KEEP_BITS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic si_pin,
    output logic so_out,
    output logic so_oe,
    output logic sio_out,
    output logic sio_oe,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_data,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic [7:0] cmd_data,
    output logic cmd_data_valid
);
    import flash_cmd_pkg::*;

    typedef struct packed {
        ctrl_state_t state;
        phase_t phase;
        cmd_class_t cls;
        logic [7:0] opcode;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [ADDR_W-1:0] addr;
        logic [7:0] out_byte;
        logic so_out;
        logic so_oe;
        logic sio_out;
        logic sio_oe;
        logic cmd_valid;
        logic [7:0] cmd_data;
        logic cmd_data_valid;
        logic data_seen;
    } ctrl_t;

    ctrl_t state_reg;
    ctrl_t state_next;
    logic [2:0] pins_sync;
    logic [2:0] pins_prev;
    logic cs_low;
    logic sclk_rise;
    logic sclk_fall;
    logic si_bit;

    spi_pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({si_pin, sclk_pin, cs_n_pin}),
        .pin_sync(pins_sync),
        .pin_prev(pins_prev)
    );

    assign cs_low = ~pins_sync[0];
    assign sclk_rise = pins_sync[1] & ~pins_prev[1];
    assign sclk_fall = ~pins_sync[1] & pins_prev[1];
    assign si_bit = pins_sync[2];

    function automatic cmd_class_t classify(input logic [7:0] op);
        case (op)
            `OP_READ_FAST: classify = CMD_READ_SINGLE;
            `OP_READ_SLOW: classify = CMD_READ_SINGLE;
            `OP_READ_DUAL: classify = CMD_READ_DUAL;
            `OP_PAGE_ERASE, `OP_BLK4_ERASE, `OP_BLK32_ERASE_A,
            `OP_BLK32_ERASE_B: classify = CMD_ADDR_ONLY;
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_CHIP_ERASE_C,
            `OP_WR_ENABLE, `OP_WR_DISABLE, `OP_POWER_DOWN,
            `OP_POWER_RESUME, `OP_ULTRA_DOWN: classify = CMD_BARE;
            `OP_PROGRAM, `OP_OTP_PROGRAM: classify = CMD_ADDR_DATA;
            `OP_OTP_READ: classify = CMD_OTP_READ;
            `OP_STATUS_READ, `OP_ID_READ, `OP_ID_LEGACY: classify = CMD_DATA_OUT;
            `OP_STATUS_WR1, `OP_STATUS_WR2, `OP_SOFT_RESET: classify = CMD_ONE_DATA;
            default: classify = CMD_NONE;
        endcase
    endfunction

    function automatic logic needs_addr(input cmd_class_t c);
        needs_addr = (c == CMD_READ_SINGLE) || (c == CMD_READ_DUAL) ||
            (c == CMD_ADDR_ONLY) || (c == CMD_ADDR_DATA) || (c == CMD_OTP_READ);
    endfunction

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(`ADDR_TOP)) begin
            next_addr = '0;
        end else begin
            next_addr = a + ADDR_W'(1);
        end
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.cmd_valid = 1'b0;
        state_next.cmd_data_valid = 1'b0;
        case (state_reg.state)
            ST_IDLE: begin
                state_next.so_oe = 1'b0;
                state_next.sio_oe = 1'b0;
                if (cs_low) begin
                    state_next.state = ST_ACTIVE;
                    state_next.phase = PH_OPCODE;
                    state_next.bit_cnt = 3'h0;
                    state_next.byte_cnt = 2'h0;
                    state_next.data_seen = 1'b0;
                    state_next.cls = CMD_NONE;
                end
            end
            ST_ACTIVE: begin
                if (!cs_low) begin
                    state_next.state = ST_IDLE;
                    state_next.so_oe = 1'b0;
                    state_next.sio_oe = 1'b0;
                    if (state_reg.phase == PH_DATA && state_reg.bit_cnt == 3'h0) begin
                        case (state_reg.cls)
                            CMD_ADDR_ONLY: state_next.cmd_valid = 1'b1;
                            CMD_ADDR_DATA: state_next.cmd_valid = state_reg.data_seen;
                            CMD_ONE_DATA: state_next.cmd_valid = state_reg.data_seen;
                            default: state_next.cmd_valid = 1'b0;
                        endcase
                    end else if (state_reg.phase == PH_OPCODE && state_reg.cls == CMD_BARE
                        && state_reg.bit_cnt == 3'h0) begin
                        state_next.cmd_valid = 1'b1;
                    end
                end else if (sclk_rise) begin
                    state_next.shift = {state_reg.shift[6:0], si_bit};
                    state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
                    if (state_reg.bit_cnt == 3'h7) begin
                        case (state_reg.phase)
                            PH_OPCODE: begin
                                if (state_reg.cls == CMD_NONE) begin
                                    state_next.opcode = {state_reg.shift[6:0], si_bit};
                                    state_next.cls = classify({state_reg.shift[6:0], si_bit});
                                    state_next.byte_cnt = 2'h0;
                                    if (classify({state_reg.shift[6:0], si_bit}) == CMD_NONE) begin
                                        state_next.state = ST_IGNORE;
                                    end else if (needs_addr(classify({state_reg.shift[6:0], si_bit}))) begin
                                        state_next.phase = PH_ADDR;
                                    end else if (classify({state_reg.shift[6:0], si_bit}) != CMD_BARE) begin
                                        state_next.phase = PH_DATA;
                                    end
                                end
                            end
                            PH_ADDR: begin
                                state_next.addr = ADDR_W'({state_reg.addr, state_reg.shift[6:0], si_bit});
                                state_next.byte_cnt = state_reg.byte_cnt + 2'h1;
                                if (state_reg.byte_cnt == 2'(`ADDR_BYTES - 1)) begin
                                    state_next.byte_cnt = 2'h0;
                                    if (state_reg.opcode == `OP_READ_SLOW ||
                                        state_reg.cls == CMD_ADDR_ONLY ||
                                        state_reg.cls == CMD_ADDR_DATA) begin
                                        state_next.phase = PH_DATA;
                                    end else begin
                                        state_next.phase = PH_DUMMY;
                                    end
                                end
                            end
                            PH_DUMMY: begin
                                state_next.byte_cnt = state_reg.byte_cnt + 2'h1;
                                if (state_reg.cls != CMD_OTP_READ ||
                                    state_reg.byte_cnt == 2'(`OTP_DUMMY_BYTES - 1)) begin
                                    state_next.phase = PH_DATA;
                                end
                            end
                            PH_DATA: begin
                                state_next.data_seen = 1'b1;
                                state_next.cmd_data = {state_reg.shift[6:0], si_bit};
                                state_next.cmd_data_valid = (state_reg.cls == CMD_ADDR_DATA) ||
                                    (state_reg.cls == CMD_ONE_DATA && !state_reg.data_seen);
                            end
                            default: state_next.phase = PH_OPCODE;
                        endcase
                    end
                    // dual read steps two bits per clock
                    if (state_reg.phase == PH_DATA && state_reg.cls == CMD_READ_DUAL) begin
                        state_next.bit_cnt = state_reg.bit_cnt + 3'h2;
                    end
                end else if (sclk_fall && state_reg.phase == PH_DATA) begin
                    if (state_reg.cls == CMD_READ_SINGLE) begin
                        state_next.so_oe = 1'b1;
                        state_next.so_out = state_reg.out_byte[3'h7 - state_reg.bit_cnt];
                        if (state_reg.bit_cnt == 3'h7) begin
                            state_next.addr = next_addr(state_reg.addr);
                        end
                    end else if (state_reg.cls == CMD_READ_DUAL) begin
                        state_next.so_oe = 1'b1;
                        state_next.sio_oe = 1'b1;
                        state_next.so_out = state_reg.out_byte[3'h7 - state_reg.bit_cnt];
                        state_next.sio_out = state_reg.out_byte[3'h6 - state_reg.bit_cnt];
                        if (state_reg.bit_cnt == 3'h6) begin
                            state_next.addr = next_addr(state_reg.addr);
                        end
                    end
                end
                if (state_reg.phase == PH_DATA && state_reg.bit_cnt == 3'h0 && !sclk_fall) begin
                    state_next.out_byte = mem_data;
                end
            end
            ST_IGNORE: begin
                state_next.so_oe = 1'b0;
                state_next.sio_oe = 1'b0;
                if (!cs_low) begin
                    state_next.state = ST_IDLE;
                end
            end
            default: state_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.state <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_addr <= '0;
            cmd_opcode <= 8'h00;
            cmd_addr <= '0;
        end else begin
            mem_addr <= state_next.addr;
            cmd_opcode <= state_next.opcode;
            cmd_addr <= state_next.addr;
        end
    end

    assign so_out = state_reg.so_out;
    assign so_oe = state_reg.so_oe;
    assign sio_out = state_reg.sio_out;
    assign sio_oe = state_reg.sio_oe;
    assign cmd_valid = state_reg.cmd_valid;
    assign cmd_data = state_reg.cmd_data;
    assign cmd_data_valid = state_reg.cmd_data_valid;
endmodule

/* serial_flash_command_read_props.sv */
`timescale 1ns/100ps
module serial_flash_command_read_chk #(
    parameter int ADDR_W = 17
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic sio_out,
    input wire logic sio_oe,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic cmd_valid,
    input wire logic cmd_data_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    so_release_a: assert property (cs_n_pin [*6] |-> !so_oe)
        else $error("serial output driven while deselected");
    sio_release_a: assert property (cs_n_pin [*6] |-> !sio_oe)
        else $error("input line driven while deselected");
    dual_pair_a: assert property (sio_oe |-> so_oe)
        else $error("input line driven without serial output");
    fall_shift_a: assert property (sclk_pin [*4] |-> $stable(so_out) && $stable(sio_out))
        else $error("output changed while serial clock high");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    cmd_at_end_a: assert property (cmd_valid |-> cs_n_pin && $past(cs_n_pin, 2))
        else $error("command pulse before deselect");
    data_pulse_a: assert property (cmd_data_valid |=> !cmd_data_valid)
        else $error("data pulse longer than one cycle");
    oe_select_a: assert property ($rose(so_oe) |-> !$past(cs_n_pin, 3))
        else $error("output enabled without selection");
    addr_step_a: assert property (so_oe && $past(so_oe) && $changed(mem_addr)
        |-> mem_addr == ADDR_W'($past(mem_addr) + 1))
        else $error("read address did not step by one");

    dual_seen_c: cover property (sio_oe);
    cmd_seen_c: cover property (cmd_valid);
    data_seen_c: cover property (cmd_data_valid);
endmodule

bind serial_flash_command_read serial_flash_command_read_chk #(.ADDR_W(ADDR_W)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .so_out(so_out), .so_oe(so_oe), .sio_out(sio_out), .sio_oe(sio_oe),
    .mem_addr(mem_addr), .cmd_valid(cmd_valid), .cmd_data_valid(cmd_data_valid)
);

/* spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    input wire logic core_clk,
    input wire logic so_line,
    input wire logic sio_line,
    output logic cs_n,
    output logic sclk,
    output logic si_drv,
    output logic si_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si_drv = 1'b0;
        si_oe = 1'b0;
    end

    task automatic begin_frame();
        @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // deselect ends frame, clock idles low
    task automatic end_frame();
        sclk <= 1'b0;
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        si_oe <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    // msb first, mode 0, clock 3.125 MHz
    task automatic shift(input logic [7:0] b, input int nb, input bit dual,
        output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < nb; i++) begin
            sclk <= 1'b0;
            si_drv <= b[7-i];
            si_oe <= !dual;
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk);
            r = dual ? {r[5:0], so_line, sio_line} : {r[6:0], so_line};
        end
    endtask
endmodule

/* serial_flash_command_read_bench.sv */
`timescale 1ns/100ps
module serial_flash_command_read_bench;
    logic core_clk, sys_rst, cs_n_pin, sclk_pin, si_drv, si_oe, idle_pat;
    logic so_out, so_oe, sio_out, sio_oe, cmd_valid, cmd_data_valid;
    logic [16:0] mem_addr, cmd_addr;
    logic [7:0] mem_data, cmd_opcode, cmd_data;
    wire logic si_pin;
    wire logic so_line;
    logic [7:0] mem_rand [256];
    logic [7:0] vq[$];
    logic [7:0] dq[$];
    logic [16:0] aq[$];
    logic [7:0] ops [15] = '{8'h60, 8'hC7, 8'h62, 8'h06, 8'h04, 8'hB9, 8'hAB, 8'h79,
        8'h81, 8'h20, 8'h52, 8'hD8, 8'h01, 8'h31, 8'hF0};
    int miscompares, samples_checked, oe_seen;

    function automatic logic [7:0] mem_byte(input int a);
        return mem_rand[a[7:0]] ^ a[15:8] ^ {a[16], 7'h00};
    endfunction

    assign mem_data = mem_byte(int'(mem_addr));
    assign si_pin = si_oe ? si_drv : (sio_oe ? sio_out : idle_pat);
    assign so_line = so_oe ? so_out : idle_pat;

    serial_flash_command_read u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe), .sio_out(sio_out),
        .sio_oe(sio_oe), .mem_addr(mem_addr), .mem_data(mem_data), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_data_valid(cmd_data_valid)
    );
    spi_host_model u_host (
        .core_clk(core_clk), .so_line(so_line), .sio_line(si_pin), .cs_n(cs_n_pin),
        .sclk(sclk_pin), .si_drv(si_drv), .si_oe(si_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        idle_pat <= ~idle_pat;
        if (cmd_valid === 1'b1) begin
            vq.push_back(cmd_opcode);
            aq.push_back(cmd_addr);
        end
        if (cmd_data_valid === 1'b1)
            dq.push_back(cmd_data);
        if (so_oe === 1'b1)
            oe_seen++;
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic run_cmd(input logic [7:0] op, input int na, input int nd, input bit ok);
        logic [7:0] r;
        logic [23:0] a;
        logic [7:0] ed[$];
        a = 24'($urandom);
        vq.delete();
        aq.delete();
        dq.delete();
        oe_seen = 0;
        u_host.begin_frame();
        u_host.shift(op, 8, 1'b0, r);
        for (int i = 0; i < na; i++)
            u_host.shift(a[23-8*i -: 8], 8, 1'b0, r);
        for (int i = 0; i < nd; i++) begin
            ed.push_back((i == 0 && !ok) ? 8'h03 : 8'($urandom));
            u_host.shift(ed[i], 8, 1'b0, r);
        end
        u_host.end_frame();
        check(17'(vq.size()), ok ? 17'h1 : 17'h0);
        check(17'(dq.size()), ok ? 17'(nd) : 17'h0);
        check(17'(oe_seen), 17'h0);
        if (ok) check(17'(vq[0]), 17'(op));
        if (ok && na == 3) check(aq[0], a[16:0]);
        foreach (dq[i]) check(17'(dq[i]), 17'(ed[i]));
    endtask

    task automatic run_read(input logic [7:0] op, input logic [23:0] a, input int n,
        input int part);
        logic [7:0] r;
        int ad;
        bit dual;
        dual = (op == 8'h3B);
        ad = int'(a[16:0]);
        u_host.begin_frame();
        u_host.shift(op, 8, 1'b0, r);
        for (int i = 0; i < 3; i++)
            u_host.shift(a[23-8*i -: 8], 8, 1'b0, r);
        if (op != 8'h03)
            u_host.shift(8'($urandom), 8, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            u_host.shift(8'hFF, dual ? 4 : 8, dual, r);
            check(17'(r), 17'(mem_byte(ad)));
            check(17'({so_oe, sio_oe}), 17'({1'b1, dual}));
            ad = (ad + 1) % 131072;
        end
        u_host.shift(8'hFF, part, dual, r);
        u_host.end_frame();
        check(17'({so_oe, sio_oe}), 17'h0);
    endtask

    initial begin
        sys_rst = 1'b1;
        idle_pat = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        oe_seen = 0;
        void'($urandom(32'hD87E9EF7));
        foreach (mem_rand[i]) mem_rand[i] = 8'($urandom);
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        run_read(8'h03, {7'h55, 17'($urandom)}, 3, 0);
        run_read(8'h0B, 24'hFFFFFE, 4, 0);
        run_read(8'h3B, 24'h81FFFF, 2, 2);
        run_read(8'h03, 24'($urandom), 1, 3);
        run_cmd(8'h00, 0, 6, 1'b0);
        run_cmd(8'hFF, 3, 2, 1'b0);
        run_cmd(8'h20, 1, 0, 1'b0);
        run_cmd(8'h02, 3, 0, 1'b0);
        run_read(8'h0B, 24'($urandom), 2, 5);
        foreach (ops[i]) run_cmd(ops[i], (i / 4 == 2) ? 3 : 0, (i > 11) ? 1 : 0, 1'b1);
        run_cmd(8'h02, 3, 3, 1'b1);
        run_cmd(8'h9B, 3, 2, 1'b1);
        print_verdict();
    end

    initial begin
        #(3000000);
        miscompares++;
        print_verdict();
    end
endmodule
